// ==== rtl/ref_select_pkg.sv ====
// Package for the reference select and loss detect block.
// Holds register offsets, field positions, reset values and timing counts.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package ref_select_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFFS_TUNE_CTRL = 8'h00;
   localparam logic [7:0] OFFS_INPUT_CFG = 8'h04;
   localparam logic [7:0] OFFS_FIRST_DIV = 8'h08;
   localparam logic [7:0] OFFS_SECOND_DIV = 8'h0c;
   localparam logic [7:0] OFFS_STATUS = 8'h10;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int FLD_RX_KIND_LSB = 0;
   localparam int FLD_SELECT_LSB = 2;
   localparam int FLD_TIMEOUT_LSB = 4;
   localparam int FLD_PINFMT_LSB = 6;
   localparam int STS_LOST_A = 0;
   localparam int STS_LOST_B = 1;
   localparam int STS_ACTIVE_B = 2;
   localparam int STS_TUNE_PENDING = 3;
   localparam int STS_LOOP_LOCKED = 4;
   localparam int STS_DIV_INVALID = 5;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic RST_TUNE_WAIT = 1'b0;
   localparam logic [1:0] RST_RX_KIND = 2'h0;
   localparam logic [1:0] RST_SELECT = 2'h0;
   localparam logic [1:0] RST_TIMEOUT = 2'h0;
   localparam logic [1:0] RST_PINFMT = 2'h0;
   localparam logic [11:0] RST_FIRST_DIV = 12'h001;

   // ****************************************************************
   // Selection modes and pin formats
   // ****************************************************************
   localparam logic [1:0] SEL_FORCE_A = 2'h0;
   localparam logic [1:0] SEL_FORCE_B = 2'h1;
   localparam logic [1:0] SEL_NONREVERT = 2'h2;
   localparam logic [1:0] SEL_REVERT = 2'h3;
   localparam logic [1:0] PIN_RESERVED = 2'h0;
   localparam logic [1:0] PIN_NMOS_OD = 2'h1;
   localparam logic [1:0] PIN_PMOS_OD = 2'h2;
   localparam logic [1:0] PIN_CMOS = 2'h3;

   // ****************************************************************
   // Loss timeouts: one period of the minimum frequency, rounded up
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int MIN_FREQ_KHZ_0 = 1000;
   localparam int MIN_FREQ_KHZ_1 = 3000;
   localparam int MIN_FREQ_KHZ_2 = 13000;
   localparam int MIN_FREQ_KHZ_3 = 32000;
   localparam int PS_PER_KHZ_PERIOD = 1000000000;
   localparam int TMO_CYC_0 = (PS_PER_KHZ_PERIOD + MIN_FREQ_KHZ_0 * CLK_PERIOD_PS - 1)
                              / (MIN_FREQ_KHZ_0 * CLK_PERIOD_PS);
   localparam int TMO_CYC_1 = (PS_PER_KHZ_PERIOD + MIN_FREQ_KHZ_1 * CLK_PERIOD_PS - 1)
                              / (MIN_FREQ_KHZ_1 * CLK_PERIOD_PS);
   localparam int TMO_CYC_2 = (PS_PER_KHZ_PERIOD + MIN_FREQ_KHZ_2 * CLK_PERIOD_PS - 1)
                              / (MIN_FREQ_KHZ_2 * CLK_PERIOD_PS);
   localparam int TMO_CYC_3 = (PS_PER_KHZ_PERIOD + MIN_FREQ_KHZ_3 * CLK_PERIOD_PS - 1)
                              / (MIN_FREQ_KHZ_3 * CLK_PERIOD_PS);
   localparam int TMO_W = 8;

endpackage

// ==== rtl/reference_select_and_loss_detect.sv ====
// Reference selection, loss detection, first-loop divider and tune trigger.
// Assumes reference inputs and lock input are synchronous to mclk_in,
// and software access over Avalon-MM with waitrequest.

`timescale 1ns/1ps

module reference_select_and_loss_detect
   import ref_select_pkg::*;
#(
   parameter int SECOND_DIV_W = 18
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic ref_input_a_in,
   input wire logic ref_input_b_in,
   input wire logic first_loop_locked_in,
   output logic input_a_signal_lost_out,
   output logic input_a_signal_lost_oe_out,
   output logic input_b_signal_lost_out,
   output logic input_b_signal_lost_oe_out,
   output logic ref_a_mos_out,
   output logic ref_b_mos_out,
   output logic ref_use_b_out,
   output logic [11:0] first_loop_feedback_divider_out,
   output logic [SECOND_DIV_W-1:0] second_loop_feedback_divider_out,
   output logic tune_start_out
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic tune_wait_for_lock;
      logic [1:0] ref_receiver_kind;
      logic [1:0] ref_select_field;
      logic [1:0] signal_drop_timeout;
      logic [1:0] drop_pin_format;
      logic [11:0] first_div;
      logic [SECOND_DIV_W-1:0] second_div;
      logic tune_pending;
      logic tune_pulse;
      logic [1:0] ref_prev;
      logic [1:0][TMO_W-1:0] idle_cnt;
      logic [1:0] lost;
      logic use_b;
      logic was_nonrevert;
      logic [1:0] pin_level;
      logic [1:0] pin_oe;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Timeout count for a given minimum-frequency code
   function automatic logic [TMO_W-1:0] timeout_cycles(input logic [1:0] code);
      case (code)
         2'h0: timeout_cycles = TMO_W'(TMO_CYC_0);
         2'h1: timeout_cycles = TMO_W'(TMO_CYC_1);
         2'h2: timeout_cycles = TMO_W'(TMO_CYC_2);
         default: timeout_cycles = TMO_W'(TMO_CYC_3);
      endcase
   endfunction

   // Pin enable for a format and level; open-drain only drives one level
   function automatic logic pin_enable(input logic [1:0] fmt, input logic level);
      case (fmt)
         PIN_NMOS_OD: pin_enable = ~level;
         PIN_PMOS_OD: pin_enable = level;
         PIN_CMOS: pin_enable = 1'b1;
         default: pin_enable = 1'b0;
      endcase
   endfunction

   logic [1:0] ref_now;
   logic wr_go;
   logic tune_fire;
   logic [1:0] ref_edge;
   logic auto_mode;

   assign ref_now = {ref_input_b_in, ref_input_a_in};

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb
   begin
      state_next = state_reg;
      // Access completes in the cycle waitrequest is low
      wr_go = avs_write_in & ~state_reg.waitreq;
      tune_fire = 1'b0;
      ref_edge = ref_now & ~state_reg.ref_prev;
      auto_mode = state_reg.ref_select_field[1];

      // Bus handshake: one wait cycle, then a single answer cycle
      state_next.waitreq = 1'b1;
      if ((avs_read_in | avs_write_in) & state_reg.waitreq)
      begin
         state_next.waitreq = 1'b0;
      end
      // Read data stands for the answer cycle only, zero otherwise
      state_next.rdata = 32'h0;
      if (avs_read_in & state_reg.waitreq)
      begin
         case (avs_address_in)
            OFFS_TUNE_CTRL: state_next.rdata[0] = state_reg.tune_wait_for_lock;
            OFFS_INPUT_CFG:
            begin
               state_next.rdata[FLD_RX_KIND_LSB +: 2] = state_reg.ref_receiver_kind;
               state_next.rdata[FLD_SELECT_LSB +: 2] = state_reg.ref_select_field;
               state_next.rdata[FLD_TIMEOUT_LSB +: 2] = state_reg.signal_drop_timeout;
               state_next.rdata[FLD_PINFMT_LSB +: 2] = state_reg.drop_pin_format;
            end
            OFFS_FIRST_DIV: state_next.rdata[11:0] = state_reg.first_div;
            OFFS_SECOND_DIV: state_next.rdata[SECOND_DIV_W-1:0] = state_reg.second_div;
            OFFS_STATUS:
            begin
               state_next.rdata[STS_LOST_A] = state_reg.lost[0];
               state_next.rdata[STS_LOST_B] = state_reg.lost[1];
               state_next.rdata[STS_ACTIVE_B] = state_reg.use_b;
               state_next.rdata[STS_TUNE_PENDING] = state_reg.tune_pending;
               state_next.rdata[STS_LOOP_LOCKED] = first_loop_locked_in;
               state_next.rdata[STS_DIV_INVALID] = (state_reg.first_div == 12'h000);
            end
            default: state_next.rdata = 32'h0;
         endcase
      end
      // Register writes; unmapped and status writes are dropped
      if (wr_go)
      begin
         case (avs_address_in)
            OFFS_TUNE_CTRL: state_next.tune_wait_for_lock = avs_writedata_in[0];
            OFFS_INPUT_CFG:
            begin
               state_next.ref_receiver_kind = avs_writedata_in[FLD_RX_KIND_LSB +: 2];
               state_next.ref_select_field = avs_writedata_in[FLD_SELECT_LSB +: 2];
               state_next.signal_drop_timeout = avs_writedata_in[FLD_TIMEOUT_LSB +: 2];
               state_next.drop_pin_format = avs_writedata_in[FLD_PINFMT_LSB +: 2];
            end
            // Zero is stored as written and flagged in status
            OFFS_FIRST_DIV: state_next.first_div = avs_writedata_in[11:0];
            OFFS_SECOND_DIV: state_next.second_div = avs_writedata_in[SECOND_DIV_W-1:0];
            default: state_next.tune_pending = state_reg.tune_pending;
         endcase
      end

      // Tune trigger: waits for lock only when asked to
      if (state_reg.tune_pending)
      begin
         if (!state_reg.tune_wait_for_lock)
         begin
            tune_fire = 1'b1;
         end
         else if (first_loop_locked_in)
         begin
            tune_fire = 1'b1;
         end
      end
      state_next.tune_pulse = tune_fire;
      // A second-divider write in the firing cycle rearms, so no update is lost
      state_next.tune_pending = (state_reg.tune_pending & ~tune_fire) |
                                (wr_go & (avs_address_in == OFFS_SECOND_DIV));

      // Loss detectors, one per input, sharing the timeout field
      state_next.ref_prev = ref_now;
      for (int i = 0; i < 2; i++)
      begin
         if (ref_edge[i])
         begin
            state_next.idle_cnt[i] = '0;
            state_next.lost[i] = 1'b0;
         end
         else if (state_reg.idle_cnt[i] >= timeout_cycles(state_reg.signal_drop_timeout))
         begin
            state_next.lost[i] = 1'b1;
         end
         else
         begin
            state_next.idle_cnt[i] = state_reg.idle_cnt[i] + TMO_W'(1);
         end
      end

      // Reference choice; the first loop follows it whatever the tune bit
      state_next.was_nonrevert = (state_reg.ref_select_field == SEL_NONREVERT);
      case (state_reg.ref_select_field)
         SEL_FORCE_A: state_next.use_b = 1'b0;
         SEL_FORCE_B: state_next.use_b = 1'b1;
         SEL_NONREVERT:
         begin
            if (!state_reg.was_nonrevert)
            begin
               state_next.use_b = 1'b0;
            end
            else if (!state_reg.use_b && state_reg.lost[0] && !state_reg.lost[1])
            begin
               state_next.use_b = 1'b1;
            end
            else if (state_reg.use_b && state_reg.lost[1] && !state_reg.lost[0])
            begin
               state_next.use_b = 1'b0;
            end
         end
         SEL_REVERT:
         begin
            // Both lost keeps the preferred input
            state_next.use_b = state_reg.lost[0] & ~state_reg.lost[1];
         end
         default: state_next.use_b = 1'b0;
      endcase

      // Loss pins show status only in automatic modes
      for (int i = 0; i < 2; i++)
      begin
         state_next.pin_level[i] = auto_mode & state_reg.lost[i];
         state_next.pin_oe[i] = pin_enable(state_reg.drop_pin_format,
                                           auto_mode & state_reg.lost[i]);
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_reg <= '0;
         state_reg.waitreq <= 1'b1;
         state_reg.tune_wait_for_lock <= RST_TUNE_WAIT;
         state_reg.ref_receiver_kind <= RST_RX_KIND;
         state_reg.ref_select_field <= RST_SELECT;
         state_reg.signal_drop_timeout <= RST_TIMEOUT;
         state_reg.drop_pin_format <= RST_PINFMT;
         state_reg.first_div <= RST_FIRST_DIV;
         // No edge seen yet, so both inputs start out lost
         state_reg.lost <= 2'h3;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Outputs, all straight from the state register
   // ****************************************************************
   assign avs_readdata_out = state_reg.rdata;
   assign avs_waitrequest_out = state_reg.waitreq;
   assign input_a_signal_lost_out = state_reg.pin_level[0];
   assign input_a_signal_lost_oe_out = state_reg.pin_oe[0];
   assign input_b_signal_lost_out = state_reg.pin_level[1];
   assign input_b_signal_lost_oe_out = state_reg.pin_oe[1];
   assign ref_a_mos_out = state_reg.ref_receiver_kind[0];
   assign ref_b_mos_out = state_reg.ref_receiver_kind[1];
   assign ref_use_b_out = state_reg.use_b;
   assign first_loop_feedback_divider_out = state_reg.first_div;
   assign second_loop_feedback_divider_out = state_reg.second_div;
   assign tune_start_out = state_reg.tune_pulse;

endmodule // reference_select_and_loss_detect

// ==== tb/ref_select_chk.sv ====
// Checker for bus timing, tune trigger, selection and loss pins.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module ref_select_chk
   import ref_select_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic first_loop_locked_in,
   input wire logic input_a_signal_lost_out,
   input wire logic input_a_signal_lost_oe_out,
   input wire logic input_b_signal_lost_out,
   input wire logic ref_use_b_out,
   input wire logic tune_start_out
);
   // ************************************
   // Shadow of written fields
   // ************************************
   logic tune_wait_reg;
   logic [1:0] sel_reg;
   logic [1:0] fmt_reg;
   logic wr_done;
   assign wr_done = avs_write_in && !avs_waitrequest_out;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   // Follow host writes, since fields are not visible at the ports
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         tune_wait_reg <= RST_TUNE_WAIT;
         sel_reg <= RST_SELECT;
         fmt_reg <= RST_PINFMT;
      end
      else if (wr_done && avs_address_in == OFFS_TUNE_CTRL)
         tune_wait_reg <= avs_writedata_in[0];
      else if (wr_done && avs_address_in == OFFS_INPUT_CFG)
      begin
         sel_reg <= avs_writedata_in[FLD_SELECT_LSB +: 2];
         fmt_reg <= avs_writedata_in[FLD_PINFMT_LSB +: 2];
      end
   end

   property p_bus_answer;
      (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer missing");
   property p_bus_stands;
      !avs_waitrequest_out |=> avs_waitrequest_out && avs_readdata_out == 32'h0;
   endproperty
   a_bus_stands: assert property (p_bus_stands) else $error("bus answer held");
   property p_tune_now;
      wr_done && avs_address_in == OFFS_SECOND_DIV && !tune_wait_reg
         |-> ##2 tune_start_out ##1 !tune_start_out;
   endproperty
   a_tune_now: assert property (p_tune_now) else $error("tune pulse wrong");
   property p_tune_held;
      tune_start_out && tune_wait_reg && $past(tune_wait_reg, 3)
         |-> $past(first_loop_locked_in) || $past(first_loop_locked_in, 2);
   endproperty
   a_tune_held: assert property (p_tune_held) else $error("tune before lock");
   property p_forced;
      !sel_reg[1] && sel_reg == $past(sel_reg) |-> ref_use_b_out == sel_reg[0];
   endproperty
   a_forced: assert property (p_forced) else $error("forced input wrong");
   property p_forced_pins;
      !sel_reg[1] && !$past(sel_reg[1]) && !$past(sel_reg[1], 2)
         |-> !input_a_signal_lost_out && !input_b_signal_lost_out;
   endproperty
   a_forced_pins: assert property (p_forced_pins) else $error("loss pin set");
   property p_revert;
      sel_reg == SEL_REVERT && $past(sel_reg) == SEL_REVERT && $past(sel_reg, 2) == SEL_REVERT
         |-> ref_use_b_out == (input_a_signal_lost_out && !input_b_signal_lost_out);
   endproperty
   a_revert: assert property (p_revert) else $error("revertive choice wrong");
   property p_nonrevert;
      sel_reg == SEL_NONREVERT && $past(sel_reg, 2) == SEL_NONREVERT && $changed(ref_use_b_out)
         |-> (ref_use_b_out ? input_a_signal_lost_out && !input_b_signal_lost_out
                            : input_b_signal_lost_out && !input_a_signal_lost_out);
   endproperty
   a_nonrevert: assert property (p_nonrevert) else $error("switch without loss");
   property p_pin_enable;
      fmt_reg == $past(fmt_reg) |-> input_a_signal_lost_oe_out == (fmt_reg == PIN_CMOS
         || (fmt_reg == PIN_PMOS_OD && input_a_signal_lost_out)
         || (fmt_reg == PIN_NMOS_OD && !input_a_signal_lost_out));
   endproperty
   a_pin_enable: assert property (p_pin_enable) else $error("pin enable wrong");
endmodule // ref_select_chk

bind reference_select_and_loss_detect ref_select_chk chk (.mclk_in(mclk_in),
   .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .first_loop_locked_in(first_loop_locked_in),
   .input_a_signal_lost_out(input_a_signal_lost_out),
   .input_a_signal_lost_oe_out(input_a_signal_lost_oe_out),
   .input_b_signal_lost_out(input_b_signal_lost_out), .ref_use_b_out(ref_use_b_out),
   .tune_start_out(tune_start_out));

// ==== tb/ref_source_model.sv ====
// Model of the two reference clock sources.
// Assumes sources run in step with mclk_in; a stopped source holds its level.
`timescale 1ns/1ps
module ref_source_model
(
   input wire logic mclk_in,
   input wire logic run_a_in,
   input wire logic run_b_in,
   output logic ref_a_out,
   output logic ref_b_out
);
   // Fastest clocks, so the shortest loss window still sees edges
   initial
   begin
      ref_a_out = 1'b0;
      ref_b_out = 1'b0;
   end
   always @(posedge mclk_in)
   begin
      ref_a_out <= run_a_in ? !ref_a_out : ref_a_out;
      ref_b_out <= run_b_in ? !ref_b_out : ref_b_out;
   end
endmodule // ref_source_model

// ==== tb/reference_select_and_loss_detect_bench.sv ====
// Bench for the reference select and loss detect block.
// Assumes the source model feeds both references and the checker is bound.
`timescale 1ns/1ps
module reference_select_and_loss_detect_bench import ref_select_pkg::*;;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_t;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic lock = 1'b0;
   logic run_a = 1'b1;
   logic run_b = 1'b1;
   logic [31:0] readdata;
   logic waitreq, a_lost, a_oe, b_lost, b_oe, a_mos, b_mos, use_b, tune, ref_a, ref_b;
   logic [11:0] div1;
   logic [17:0] div2;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int tunes = 0;
   int tmo_cyc [4] = '{TMO_CYC_0, TMO_CYC_1, TMO_CYC_2, TMO_CYC_3};
   row_t rows [6] = '{'{OFFS_TUNE_CTRL, 32'h1, 32'h1}, '{OFFS_INPUT_CFG, 32'h1, 32'h1},
      '{OFFS_FIRST_DIV, 32'hfff, 32'hfff}, '{8'h14, 32'hffffffff, 32'h0},
      '{OFFS_TUNE_CTRL, 32'h0, 32'h0}, '{OFFS_SECOND_DIV, 32'h3ffff, 32'h3ffff}};

   reference_select_and_loss_detect uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_readdata_out(readdata), .avs_waitrequest_out(waitreq), .ref_input_a_in(ref_a),
      .ref_input_b_in(ref_b), .first_loop_locked_in(lock), .input_a_signal_lost_out(a_lost),
      .input_a_signal_lost_oe_out(a_oe), .input_b_signal_lost_out(b_lost),
      .input_b_signal_lost_oe_out(b_oe), .ref_a_mos_out(a_mos), .ref_b_mos_out(b_mos),
      .ref_use_b_out(use_b), .first_loop_feedback_divider_out(div1),
      .second_loop_feedback_divider_out(div2), .tune_start_out(tune));
   ref_source_model src (.mclk_in(mclk_in), .run_a_in(run_a), .run_b_in(run_b),
      .ref_a_out(ref_a), .ref_b_out(ref_b));

   // ************************************
   // Clock, pulse count and hang guard
   // ************************************
   initial forever #4 mclk_in = ~mclk_in;
   always @(posedge mclk_in)
   begin
      cycles <= cycles + 1;
      tunes <= tunes + (tune === 1'b1);
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge mclk_in);
      wr <= w;
      rd <= !w;
      adr <= a;
      wdata <= d;
      @(posedge mclk_in);
      while (waitreq !== 1'b0)
         @(posedge mclk_in);
      q = readdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic cfg(input logic [1:0] sel, input logic [1:0] tmo, input logic [1:0] fmt);
      wreg(OFFS_INPUT_CFG, {24'h0, fmt, tmo, sel, 2'h0});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence: table rows, then hand-written cases
   initial
   begin
      logic [31:0] q;
      int t0;
      cyc(8);
      sys_rst_in <= 1'b0;
      check("first_div", div1, 12'h001);
      foreach (rows[i])
      begin
         wreg(rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0, q);
         check("readback", q, rows[i].q);
      end
      check("a_mos", a_mos, 1'b1);
      check("b_mos", b_mos, 1'b0);
      check("first_div", div1, 12'hfff);
      $display("register table done");
      t0 = tunes;
      wreg(OFFS_SECOND_DIV, 32'h10);
      cyc(4);
      check("tune_now", tunes - t0, 1);
      wreg(OFFS_TUNE_CTRL, 32'h1);
      t0 = tunes;
      wreg(OFFS_SECOND_DIV, 32'h20);
      cyc(20);
      check("tune_held", tunes - t0, 0);
      bus(1'b0, OFFS_STATUS, 32'h0, q);
      check("pending", q[STS_TUNE_PENDING], 1'b1);
      lock <= 1'b1;
      cyc(4);
      check("tune_lock", tunes - t0, 1);
      check("div2", div2, 32'h20);
      lock <= 1'b0;
      wreg(OFFS_TUNE_CTRL, 32'h0);
      wreg(OFFS_FIRST_DIV, 32'h0);
      bus(1'b0, OFFS_STATUS, 32'h0, q);
      check("div_zero", q[STS_DIV_INVALID], 1'b1);
      $display("tune and divider done");
      cfg(SEL_FORCE_A, 2'h3, PIN_RESERVED);
      cfg(SEL_REVERT, 2'h3, PIN_CMOS);
      run_a <= 1'b0;
      cyc(12);
      check("rev_b", use_b, 1'b1);
      check("lost_a", a_lost, 1'b1);
      for (int f = 0; f < 4; f++)
      begin
         cfg(SEL_REVERT, 2'h3, f[1:0]);
         cyc(4);
         check("oe_fmt", a_oe, f >= 2);
      end
      run_a <= 1'b1;
      cyc(8);
      check("rev_a", use_b, 1'b0);
      cfg(SEL_NONREVERT, 2'h3, PIN_CMOS);
      run_a <= 1'b0;
      cyc(12);
      check("nrev_b", use_b, 1'b1);
      run_a <= 1'b1;
      cyc(12);
      check("nrev_stay", use_b, 1'b1);
      run_b <= 1'b0;
      cyc(12);
      check("nrev_a", use_b, 1'b0);
      check("lost_b", b_lost, 1'b1);
      check("oe_b", b_oe, 1'b1);
      run_b <= 1'b1;
      // Every timeout code, slowest last; window edges from the package counts
      for (int c = 3; c >= 0; c--)
      begin
         cfg(SEL_REVERT, c[1:0], PIN_CMOS);
         run_a <= 1'b1;
         cyc(10);
         run_a <= 1'b0;
         cyc(tmo_cyc[c] - 4);
         check("slow_early", a_lost, 1'b0);
         cyc(10);
         check("slow_late", a_lost, 1'b1);
      end
      // Reset in mid-run drops back to input A and the default divider
      sys_rst_in <= 1'b1;
      cyc(2);
      check("rst_use_b", use_b, 1'b0);
      check("rst_div", div1, RST_FIRST_DIV);
      sys_rst_in <= 1'b0;
      $display("mid-run reset done");
      cfg(SEL_FORCE_B, 2'h3, PIN_RESERVED);
      cyc(12);
      check("force_b", use_b, 1'b1);
      check("force_pin", {a_lost, a_oe}, 2'h0);
      cfg(SEL_FORCE_A, 2'h3, PIN_RESERVED);
      cyc(4);
      check("force_a", use_b, 1'b0);
      $display("selection done");
      conclude();
   end
endmodule // reference_select_and_loss_detect_bench
